// [design/hpp_pkg.sv]
// Purpose: constants for the host processor bus port
// Assumes: host bus clock is sampled by the 200 MHz system clock
// Notes: register offsets are byte addresses on the 5-bit host address
//
// Summary of operation
// - address bits come from bus lines 4:0 on falling host clock with latch high
// - address uses five low bus lines, data transfers use all eight
// - byte lane zero is address bit 0, byte lane one is address bit 1
// - write data sampled on rising edge one host cycle after the strobe
// - acknowledge driven low for exactly one host clock cycle
// - read data valid on data pins at the rising edge with acknowledge low
// - host interrupt held while user request stands, also as a status bit
// - user index and direction output first, then user begin asserted
// - sixteen user locations with no hard register behind them
// - wait states until user finish, acknowledge only after it
// - eight-bit registers, 0b to 0f reserved, 10 to 1f go to user logic
// - control one reads back the control bits written by the host
// - control one bit 0 drives global set/reset, default 0
// - control one bit 5 low requests readback, default 1
// - control one bit 7 low requests reconfiguration, default 1
// - user interrupts forwarded only with control two bit 2 set
// - pending interrupt status bit cleared by a status register read
package hpp_pkg;
   localparam int unsigned SYS_CLOCK_MHZ = 200;
   localparam int unsigned SYNC_STAGES = 2;

   // register offsets
   localparam logic [4:0] OFS_PORT_CONTROL_ONE = 5'h00;
   localparam logic [4:0] OFS_PORT_CONTROL_TWO = 5'h01;
   localparam logic [4:0] OFS_SCRATCHPAD = 5'h02;
   localparam logic [4:0] OFS_PORT_STATUS = 5'h03;
   localparam logic [4:0] OFS_CONFIG_READBACK_DATA = 5'h04;
   localparam logic [4:0] OFS_READBACK_ADDRESS_LOW = 5'h05;
   localparam logic [4:0] OFS_READBACK_ADDRESS_HIGH = 5'h06;
   localparam logic [4:0] OFS_IDENTITY_BYTE_0 = 5'h07;
   localparam logic [4:0] OFS_IDENTITY_BYTE_1 = 5'h08;
   localparam logic [4:0] OFS_IDENTITY_BYTE_2 = 5'h09;
   localparam logic [4:0] OFS_IDENTITY_BYTE_3 = 5'h0a;
   localparam int unsigned USER_SPACE_BIT = 4;

   // control one fields
   localparam int unsigned C1_GLOBAL_SET_RESET = 0;
   localparam int unsigned C1_READBACK_N = 5;
   localparam int unsigned C1_RECONFIGURE_N = 7;
   localparam logic [7:0] C1_MASK = 8'ha1;
   localparam logic [7:0] C1_RESET = 8'ha0;

   // control two fields
   localparam int unsigned C2_USER_INTERRUPT_ENABLE = 2;
   localparam logic [7:0] C2_MASK = 8'h3f;
   localparam logic [7:0] C2_RESET = 8'h00;

   // status fields
   localparam int unsigned ST_IRQ_PENDING = 2;
   localparam int unsigned ST_INIT = 6;
   localparam int unsigned ST_DONE = 7;

   // synchronised pin vector layout
   localparam int unsigned PIN_HCLK = 0;
   localparam int unsigned PIN_ALE = 1;
   localparam int unsigned PIN_STROBE_N = 2;
   localparam int unsigned PIN_SEL_LOW_N = 3;
   localparam int unsigned PIN_SEL_HIGH = 4;
   localparam int unsigned PIN_WRITE = 5;
   localparam int unsigned PIN_LANE0 = 6;
   localparam int unsigned PIN_LANE1 = 7;
   localparam int unsigned PIN_USER_INTERRUPT_N_N = 8;
   localparam int unsigned PIN_DONE = 9;
   localparam int unsigned PIN_INIT = 10;
   localparam int unsigned PIN_DATA = 11;
   localparam int unsigned PIN_WIDTH = 19;

   typedef enum logic [4:0] {
      HPP_IDLE = 5'b00001,
      HPP_DATA = 5'b00010,
      HPP_USER = 5'b00100,
      HPP_ACK_LOW = 5'b01000,
      HPP_ACK_END = 5'b10000
   } hpp_state_type;

   typedef struct packed {
      logic [PIN_WIDTH-1:0] s1;
      logic [PIN_WIDTH-1:0] s2;
      logic hclk_prev;
      hpp_state_type state;
      logic [4:0] addr_lat;
      logic [4:0] addr;
      logic write;
      logic [7:0] rdata;
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] scratch;
      logic [15:0] rb_addr;
      logic pending;
      logic irq_n;
      logic ack_n;
      logic data_oe;
      logic [7:0] data_out;
      logic [3:0] uidx;
      logic urnw;
      logic ubegin;
      logic [7:0] uwdata;
   } hpp_regs_type;
endpackage

// [design/hpp_host_port.sv]
// Purpose: synchronous multiplexed-bus host port with user handshake
// Assumes: host clock and all host pins are sampled by CLOCK_I
// Notes: the bus operates on detected edges of the synchronised host clock
`timescale 1ns/1ps
module hpp_host_port
   import hpp_pkg::*;
#(
   parameter logic [31:0] IDENTITY = 32'h0000_0001 // arbitrary value
) (
   input wire logic CLOCK_I,
   input wire logic RESET_N_I,
   input wire logic HOST_INTERFACE_CLOCK_I,
   input wire logic ADDRESS_LATCH_I,
   input wire logic TRANSFER_BEGIN_STROBE_N_I,
   input wire logic SELECT_LOW_N_I,
   input wire logic SELECT_HIGH_I,
   input wire logic HOST_WRITE_NOT_READ_I,
   input wire logic BYTE_LANE_ZERO_I,
   input wire logic BYTE_LANE_ONE_I,
   input wire logic [7:0] DATA_I,
   output logic [7:0] DATA_O,
   output logic DATA_OE_O,
   output logic HOST_ACKNOWLEDGE_N_O,
   output logic HOST_INTERRUPT_N_O,
   output logic [3:0] USER_REGISTER_INDEX_O,
   output logic USER_READ_NOT_WRITE_O,
   output logic USER_BEGIN_O,
   output logic [7:0] USER_WRITE_DATA_O,
   input wire logic USER_FINISH_I,
   input wire logic [7:0] USER_READ_DATA_I,
   input wire logic USER_INTERRUPT_N_I,
   input wire logic CONFIG_DONE_I,
   input wire logic CONFIG_INIT_I,
   output logic GLOBAL_SET_RESET_O,
   output logic READBACK_REQUEST_N_O,
   output logic RECONFIGURE_N_O,
   output logic [15:0] READBACK_ADDRESS_O
);
   hpp_regs_type q;
   hpp_regs_type d;
   logic [PIN_WIDTH-1:0] pins;
   logic host_rise;
   logic host_fall;
   logic selected;
   logic [4:0] bus_addr;
   logic [7:0] reg_rd;
   logic user_req;

   // gather all foreign inputs for the two-flop synchroniser
   assign pins = {DATA_I, CONFIG_INIT_I, CONFIG_DONE_I, USER_INTERRUPT_N_I,
                  BYTE_LANE_ONE_I, BYTE_LANE_ZERO_I, HOST_WRITE_NOT_READ_I,
                  SELECT_HIGH_I, SELECT_LOW_N_I, TRANSFER_BEGIN_STROBE_N_I,
                  ADDRESS_LATCH_I, HOST_INTERFACE_CLOCK_I};

   // host clock edges and decoded request, read only from second stage
   always_comb begin
      host_rise = q.s2[PIN_HCLK] & ~q.hclk_prev;
      host_fall = ~q.s2[PIN_HCLK] & q.hclk_prev;
      selected = ~q.s2[PIN_SEL_LOW_N] & q.s2[PIN_SEL_HIGH];
      // lanes replace the two low latched address bits on every transfer
      bus_addr = {q.addr_lat[4:2], q.s2[PIN_LANE1], q.s2[PIN_LANE0]};
      user_req = ~q.s2[PIN_USER_INTERRUPT_N_N] & q.ctrl2[C2_USER_INTERRUPT_ENABLE];
   end

   // register read multiplexer, reserved locations read zero
   always_comb begin
      case (q.addr)
         OFS_PORT_CONTROL_ONE: reg_rd = q.ctrl1 & C1_MASK;
         OFS_PORT_CONTROL_TWO: reg_rd = q.ctrl2 & C2_MASK;
         OFS_SCRATCHPAD: reg_rd = q.scratch;
         OFS_PORT_STATUS: begin
            reg_rd = 8'h00;
            reg_rd[ST_IRQ_PENDING] = q.pending;
            reg_rd[ST_INIT] = q.s2[PIN_INIT];
            reg_rd[ST_DONE] = q.s2[PIN_DONE];
         end
         OFS_IDENTITY_BYTE_0: reg_rd = IDENTITY[7:0];
         OFS_IDENTITY_BYTE_1: reg_rd = IDENTITY[15:8];
         OFS_IDENTITY_BYTE_2: reg_rd = IDENTITY[23:16];
         OFS_IDENTITY_BYTE_3: reg_rd = IDENTITY[31:24];
         default: reg_rd = 8'h00;
      endcase
   end

   // next-state logic for the whole port
   always_comb begin
      d = q;
      d.s1 = pins;
      d.s2 = q.s1;
      d.hclk_prev = q.s2[PIN_HCLK];
      // interrupt level follows the user request, no bus involvement
      d.irq_n = ~user_req;
      case (q.state)
         HPP_IDLE: begin
            // address captured on falling host edge while latch is high
            if (host_fall && q.s2[PIN_ALE]) begin
               d.addr_lat = q.s2[PIN_DATA +: 5];
            end
            if (host_rise && !q.s2[PIN_STROBE_N] && selected) begin
               d.addr = bus_addr;
               d.write = q.s2[PIN_WRITE];
               // index and direction go out ahead of user begin
               d.uidx = bus_addr[3:0];
               d.urnw = ~q.s2[PIN_WRITE];
               d.state = HPP_DATA;
            end
         end
         HPP_DATA: begin
            if (host_rise) begin
               if (q.addr[USER_SPACE_BIT]) begin
                  // user space: hand the transfer to user logic
                  d.ubegin = 1'b1;
                  d.uwdata = q.s2[PIN_DATA +: 8];
                  d.state = HPP_USER;
               end else begin
                  if (q.write) begin
                     case (q.addr)
                        OFS_PORT_CONTROL_ONE: d.ctrl1 = q.s2[PIN_DATA +: 8] & C1_MASK;
                        OFS_PORT_CONTROL_TWO: d.ctrl2 = q.s2[PIN_DATA +: 8] & C2_MASK;
                        OFS_SCRATCHPAD: d.scratch = q.s2[PIN_DATA +: 8];
                        OFS_READBACK_ADDRESS_LOW: d.rb_addr[7:0] = q.s2[PIN_DATA +: 8];
                        OFS_READBACK_ADDRESS_HIGH: d.rb_addr[15:8] = q.s2[PIN_DATA +: 8];
                        default: d.rb_addr = q.rb_addr;
                     endcase
                  end else begin
                     d.rdata = reg_rd;
                  end
                  d.state = HPP_ACK_LOW;
               end
            end
         end
         HPP_USER: begin
            // wait states last until user logic finishes
            if (USER_FINISH_I) begin
               d.ubegin = 1'b0;
               if (!q.write) begin
                  d.rdata = USER_READ_DATA_I;
               end
               d.state = HPP_ACK_LOW;
            end
         end
         HPP_ACK_LOW: begin
            // drive on falling edge so data is stable at the rising edge
            if (host_fall) begin
               d.ack_n = 1'b0;
               d.data_oe = ~q.write;
               d.data_out = q.rdata;
               d.state = HPP_ACK_END;
            end
         end
         HPP_ACK_END: begin
            // one full host cycle later the acknowledge is withdrawn
            if (host_fall) begin
               d.ack_n = 1'b1;
               d.data_oe = 1'b0;
               d.state = HPP_IDLE;
            end
         end
         default: d.state = HPP_IDLE;
      endcase
      // pending bit: a request in the clearing cycle wins
      d.pending = q.pending;
      if (q.state == HPP_DATA && host_rise && !q.write && q.addr == OFS_PORT_STATUS) begin
         d.pending = 1'b0;
      end
      if (user_req) begin
         d.pending = 1'b1;
      end
   end

   // single state register, reset leaves defaults in control one
   always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         q <= '0;
         q.state <= HPP_IDLE;
         q.ctrl1 <= C1_RESET;
         q.ctrl2 <= C2_RESET;
         q.irq_n <= 1'b1;
         q.ack_n <= 1'b1;
         q.urnw <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign DATA_O = q.data_out;
   assign DATA_OE_O = q.data_oe;
   assign HOST_ACKNOWLEDGE_N_O = q.ack_n;
   assign HOST_INTERRUPT_N_O = q.irq_n;
   assign USER_REGISTER_INDEX_O = q.uidx;
   assign USER_READ_NOT_WRITE_O = q.urnw;
   assign USER_BEGIN_O = q.ubegin;
   assign USER_WRITE_DATA_O = q.uwdata;
   assign GLOBAL_SET_RESET_O = q.ctrl1[C1_GLOBAL_SET_RESET];
   assign READBACK_REQUEST_N_O = q.ctrl1[C1_READBACK_N];
   assign RECONFIGURE_N_O = q.ctrl1[C1_RECONFIGURE_N];
   assign READBACK_ADDRESS_O = q.rb_addr;
endmodule

// [test/hpp_monitor.sv]
// Purpose: port checks for the host port
// Assumes: host clock near 64 ns
// Notes: bound to hpp_host_port
`timescale 1ns/1ps
module hpp_monitor (
   input wire logic CLOCK_I,
   input wire logic RESET_N_I,
   input wire logic HOST_ACKNOWLEDGE_N_O,
   input wire logic DATA_OE_O,
   input wire logic HOST_INTERRUPT_N_O,
   input wire logic USER_INTERRUPT_N_I,
   input wire logic USER_BEGIN_O,
   input wire logic USER_FINISH_I,
   input wire logic [3:0] USER_REGISTER_INDEX_O,
   input wire logic USER_READ_NOT_WRITE_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESET_N_I);
   // ack stays low about one host period
   sequence s_ack_low;
      !HOST_ACKNOWLEDGE_N_O [*8];
   endsequence
   chk_ack_pulse: assert property ($fell(HOST_ACKNOWLEDGE_N_O) |->
      s_ack_low ##[1:8] HOST_ACKNOWLEDGE_N_O) else $error("ack pulse length");
   chk_oe_ack: assert property ($rose(DATA_OE_O) |-> !HOST_ACKNOWLEDGE_N_O)
      else $error("read drive without ack");
   chk_index_first: assert property ($rose(USER_BEGIN_O) |->
      $stable(USER_REGISTER_INDEX_O) && $stable(USER_READ_NOT_WRITE_O)) else $error("index late");
   chk_begin_held: assert property (USER_BEGIN_O && !USER_FINISH_I |=> USER_BEGIN_O)
      else $error("begin dropped");
   chk_begin_ends: assert property (USER_BEGIN_O && USER_FINISH_I |=> !USER_BEGIN_O)
      else $error("begin stuck");
   chk_user_wait: assert property (USER_BEGIN_O |-> HOST_ACKNOWLEDGE_N_O)
      else $error("ack before finish");
   chk_ack_after: assert property ($fell(USER_BEGIN_O) |-> ##[1:20] !HOST_ACKNOWLEDGE_N_O)
      else $error("no ack after finish");
   chk_irq_quiet: assert property (USER_INTERRUPT_N_I [*4] |=> HOST_INTERRUPT_N_O)
      else $error("irq without request");
endmodule

bind hpp_host_port hpp_monitor mon (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
   .HOST_ACKNOWLEDGE_N_O(HOST_ACKNOWLEDGE_N_O), .DATA_OE_O(DATA_OE_O),
   .HOST_INTERRUPT_N_O(HOST_INTERRUPT_N_O), .USER_INTERRUPT_N_I(USER_INTERRUPT_N_I),
   .USER_BEGIN_O(USER_BEGIN_O), .USER_FINISH_I(USER_FINISH_I),
   .USER_REGISTER_INDEX_O(USER_REGISTER_INDEX_O), .USER_READ_NOT_WRITE_O(USER_READ_NOT_WRITE_O));

// [test/hpp_host_model.sv]
// Purpose: host processor on the shared bus
// Assumes: free-running host clock
// Notes: a released bus shows inverted data
`timescale 1ns/1ps
module hpp_host_model (
   output logic hclk_o,
   output logic ale_o,
   output logic stb_n_o,
   output logic sl_n_o,
   output logic sh_o,
   output logic wnr_o,
   output logic [1:0] lane_o,
   output logic [7:0] bus_o,
   input wire logic [7:0] dev_i,
   input wire logic oe_i,
   input wire logic ack_n_i
);
   logic [7:0] drv = 8'h00;
   logic sel_ok = 1'b1;
   // wire level from both drivers
   assign bus_o = oe_i ? dev_i : drv;
   initial begin
      {ale_o, stb_n_o, sl_n_o, sh_o, wnr_o, lane_o} = 7'b0110000;
      hclk_o = 1'b0;
      #7;
      forever #32 hclk_o = ~hclk_o;
   end
   // one transfer, held until ack seen low or 40 host cycles pass
   task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] wd,
         output logic [7:0] rd, output logic ok);
      ok = 1'b0;
      rd = 8'hxx;
      @(posedge hclk_o) #1;
      ale_o = 1'b1;
      drv = {3'b000, a};
      // hold past the edge: the port sees clock and pins through one synchroniser
      @(negedge hclk_o) #10;
      {ale_o, stb_n_o, wnr_o, lane_o} = {2'b00, wr, a[1:0]};
      {sl_n_o, sh_o} = {~sel_ok, sel_ok};
      // strobe must still be low when the port samples the rising edge
      @(posedge hclk_o) #10;
      stb_n_o = 1'b1;
      drv = wr ? wd : ~drv;
      for (int n = 0; n < 40 && !ok; n++) begin
         @(posedge hclk_o);
         ok = (ack_n_i === 1'b0);
         rd = oe_i ? bus_o : 8'hxx;
      end
      #1 {sl_n_o, sh_o} = 2'b10;
   endtask
endmodule

// [test/testbench.sv]
// Purpose: self-checking bench for the host port
// Assumes: user side answered here
// Notes: seed 72
`timescale 1ns/1ps
module testbench;
   import hpp_pkg::*;
   localparam logic [31:0] ID_VAL = 32'h5a3c_9612; // arbitrary value
   logic clock, reset_n, ufin_r, loop_en, user_interrupt_n_n, done, init, ok, crnw;
   logic [7:0] rd, v, cwd;
   logic [7:0] ww [16];
   logic [3:0] cidx;
   int bad_count = 0, n_checks = 0, udly = 0, ucnt = 0;
   wire hclk, ale, stb_n, sl_n, sh, wnr, oe, ack_n, irq_n, ubeg, urnw, ufin, global_set_reset, rb_n, rc_n;
   wire [1:0] lane;
   wire [7:0] bus, dout, uwd;
   wire [3:0] uidx;
   wire [15:0] rba;
   hpp_host_model h (.hclk_o(hclk), .ale_o(ale), .stb_n_o(stb_n), .sl_n_o(sl_n), .sh_o(sh),
      .wnr_o(wnr), .lane_o(lane), .bus_o(bus), .dev_i(dout), .oe_i(oe), .ack_n_i(ack_n));
   hpp_host_port #(.IDENTITY(ID_VAL)) uut (.CLOCK_I(clock), .RESET_N_I(reset_n),
      .HOST_INTERFACE_CLOCK_I(hclk), .ADDRESS_LATCH_I(ale), .TRANSFER_BEGIN_STROBE_N_I(stb_n),
      .SELECT_LOW_N_I(sl_n), .SELECT_HIGH_I(sh), .HOST_WRITE_NOT_READ_I(wnr),
      .BYTE_LANE_ZERO_I(lane[0]), .BYTE_LANE_ONE_I(lane[1]), .DATA_I(bus), .DATA_O(dout),
      .DATA_OE_O(oe), .HOST_ACKNOWLEDGE_N_O(ack_n), .HOST_INTERRUPT_N_O(irq_n),
      .USER_REGISTER_INDEX_O(uidx), .USER_READ_NOT_WRITE_O(urnw), .USER_BEGIN_O(ubeg),
      .USER_WRITE_DATA_O(uwd), .USER_FINISH_I(ufin), .USER_READ_DATA_I({uidx, ~uidx}),
      .USER_INTERRUPT_N_I(user_interrupt_n_n), .CONFIG_DONE_I(done), .CONFIG_INIT_I(init),
      .GLOBAL_SET_RESET_O(global_set_reset), .READBACK_REQUEST_N_O(rb_n), .RECONFIGURE_N_O(rc_n),
      .READBACK_ADDRESS_O(rba));
   // user side: finish after udly cycles or looped back
   assign ufin = loop_en ? ubeg : ufin_r;
   always @(negedge clock) begin
      ufin_r <= ubeg && !ufin_r && ucnt >= udly;
      ucnt <= ubeg ? ucnt + 1 : 0;
   end
   always @(posedge clock) if (ubeg && ufin) {cidx, crnw, cwd} <= {uidx, urnw, uwd};
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic wr, input logic [4:0] a, input logic [7:0] wd, input logic w);
      h.xfer(wr, a, wd, rd, ok);
      if (ok !== w) begin
         bad_count++;
         $display("MISMATCH %0t ack wait %h", $time, a);
         conclude();
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      {reset_n, ufin_r, loop_en, user_interrupt_n_n} = 4'b0001;
      {done, init} = 2'($urandom(72));
      repeat (16) @(posedge clock);
      @(negedge clock) reset_n = 1'b1;
      repeat (4) @(negedge clock);
      check({2'b00, global_set_reset, rb_n, rc_n, ack_n, irq_n, oe}, 8'h1e);
      op(1'b0, 5'h00, 8'h00, 1'b1);
      check(rd, 8'ha0);
      op(1'b0, 5'h01, 8'h00, 1'b1);
      check(rd, 8'h00);
      $display("test reset end");
      // fixed space 04 to 0f: write each, then read back
      for (int a = 4; a < 16; a++) begin
         ww[a] = 8'($urandom);
         op(1'b1, 5'(a), ww[a], 1'b1);
      end
      check(rba[7:0], ww[5]);
      check(rba[15:8], ww[6]);
      for (int a = 4; a < 16; a++) begin
         op(1'b0, 5'(a), 8'h00, 1'b1);
         check(rd, (a > 6 && a < 11) ? ID_VAL[8*(a-7) +: 8] : 8'h00);
      end
      // scratchpad and control one back to back
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'hff : 8'($urandom);
         op(1'b1, 5'h02, v, 1'b1);
         op(1'b1, 5'h00, ~v, 1'b1);
         check({5'h00, global_set_reset, rb_n, rc_n}, {5'h00, ~v[0], ~v[5], ~v[7]});
         op(1'b0, 5'h00, 8'h00, 1'b1);
         check(rd, ~v & 8'ha1);
         op(1'b0, 5'h02, 8'h00, 1'b1);
         check(rd, v);
      end
      h.sel_ok = 1'b0;
      op(1'b1, 5'h02, ~v, 1'b0);
      h.sel_ok = 1'b1;
      op(1'b0, 5'h02, 8'h00, 1'b1);
      check(rd, v);
      op(1'b1, 5'h00, 8'ha0, 1'b1);
      $display("test registers end");
      // user space, waits and loopback
      for (int i = 0; i < 16; i++) begin
         loop_en = (i % 4 == 0);
         udly = $urandom_range(40);
         v = 8'($urandom);
         op(1'b1, {1'b1, 4'(i)}, v, 1'b1);
         check({cidx, 3'b000, crnw}, {4'(i), 4'h0});
         check(cwd, v);
         op(1'b0, {1'b1, 4'(i)}, 8'h00, 1'b1);
         check({cidx, 3'b000, crnw}, {4'(i), 4'h1});
         check(rd, {4'(i), ~4'(i)});
      end
      $display("test user end");
      // interrupt masked, enabled, withdrawn, polled
      @(negedge clock) user_interrupt_n_n = 1'b0;
      repeat (20) @(negedge clock);
      check({7'h00, irq_n}, 8'h01);
      op(1'b1, 5'h01, 8'h04, 1'b1);
      check({7'h00, irq_n}, 8'h00);
      @(negedge clock) user_interrupt_n_n = 1'b1;
      repeat (20) @(negedge clock);
      check({7'h00, irq_n}, 8'h01);
      op(1'b0, 5'h03, 8'h00, 1'b1);
      check(rd, {done, init, 6'h04});
      op(1'b0, 5'h03, 8'h00, 1'b1);
      check(rd, {done, init, 6'h00});
      $display("test interrupt end");
      conclude();
   end
endmodule
